// >>> src/rtec_pkg.sv
// Package of constants for the revolver and toner end controller
// How it works
// RULE1 - Carrier turns counterclockwise only, in quarter-turn steps between stations.
// RULE2 - From rest, turn the offset angle before the first colour develops.
// RULE3 - Rest reference is taken when the actuator enters the rest sensor.
// RULE4 - Return to rest after each job, at power-on and on door change.
// RULE5 - With near-end or end, park at exchange position; home before next copy.
// RULE6 - Raise the rest fault code when the rest sensor misbehaves; code goes idle after HOME_LIMIT steps without setting REST_FAULT_O.
// RULE7 - Engage the development clutch for the one colour in development only.
// RULE8 - Agitate during process check, toner supply, and development of active colour.
// RULE9 - Alternating bias only in copy cycle; steady bias otherwise.
// RULE10 - Accept density readings only from the unit at the station.
// RULE11 - Toner supply clutch feeds only the unit at the station.
// RULE12 - End sensor high means toner present, low means absent.
// RULE13 - Take 160 end sensor samples every 4 ms while at copy position.
// RULE14 - Interval is toner-absent when 20 or more samples read low.
// RULE15 - Near-end after three consecutive absent intervals for one colour.
// RULE16 - After near-end, end when pixel count reaches ten full A4 pages.
// RULE17 - After near-end stop at later of tenth sheet or toner end.
// RULE18 - Recovery visits K, Y, C, M: feed hopper, test sensor, record pass/fail.
// RULE19 - Repeat recovery for failed cartridges; failing again keeps near-end and end.
// RULE20 - Passed cartridges clear near-end, end, pixel and sheet counters.
// RULE21 - At power-on turn the carrier three full turns before self check.
// RULE22 - Rotation against the lock reports out-of-step with the rest fault code.
// RULE23 - Order K, Y, C, M in copy mode; Y, C, M, K in printer mode.
// RULE24 - Clear a colour's absent run when an interval misses the threshold.
package rtec_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_TONER = 8'h0C;
	localparam logic [7:0] OFS_PIXEL = 8'h10;
	localparam logic [7:0] OFS_SHEET = 8'h14;
	localparam logic [7:0] OFS_TDS = 8'h18;
	// Control bits (write one to act)
	localparam int CTRL_START = 0;
	localparam int CTRL_NEXT = 1;
	localparam int CTRL_END = 2;
	localparam int CTRL_RECOVER = 3;
	localparam int CTRL_CLR_FAULT = 4;
	// Configuration bits
	localparam int CFG_PRINTER = 0;
	localparam int CFG_PC_CHECK = 1;
	localparam int CFG_SUPPLY = 2;
	localparam logic [2:0] CFG_RESET = 3'h0;
	// Carrier geometry and counts
	localparam int QUARTER_DEG = 90;
	localparam int OFFSET_DEG = 30;
	localparam int STEPS_PER_REV = 120;
	localparam int LOOSEN_TURNS = 3;
	localparam int PARK_STEP = 5;
	localparam int HOME_LIMIT = 2 * STEPS_PER_REV;
	localparam int STEP_PERIOD_CYC = 2500;
	// Toner end sensing
	localparam int CLK_KHZ = 125000;
	localparam int INTERVAL_MS = 4;
	localparam int INTERVAL_CYC = INTERVAL_MS * CLK_KHZ;
	localparam int SAMPLES = 160;
	localparam int LOW_THRESH = 20;
	localparam int ABSENT_RUN = 3;
	localparam int END_SHEETS = 10;
	localparam int END_PAGES = 10;
	localparam int A4_PIXELS = 34800000;
	localparam int HOPPER_CYC = 1250;
	// Colour codes
	localparam logic [1:0] COL_K = 2'h0;
	localparam logic [1:0] COL_Y = 2'h1;
endpackage

// >>> src/rtec_top.sv
// Revolver positioning, development gating and toner end control
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module rtec_top #(
	parameter int STEPS_REV = rtec_pkg::STEPS_PER_REV,
	parameter int STEP_CYC = rtec_pkg::STEP_PERIOD_CYC,
	parameter int IV_CYC = rtec_pkg::INTERVAL_CYC,
	parameter int HOP_CYC = rtec_pkg::HOPPER_CYC,
	parameter int PIX_END = rtec_pkg::END_PAGES * rtec_pkg::A4_PIXELS
) (
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	// AHB-Lite slave
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	// Sensors (asynchronous)
	input wire logic REST_SENSOR_I,
	input wire logic TONER_END_SENSOR_I,
	input wire logic LOCK_ENGAGED_I,
	input wire logic DOOR_OPEN_I,
	// Toner density sensor link
	input wire logic TDS_VALID_I,
	input wire logic [1:0] TDS_UNIT_I,
	input wire logic [7:0] TDS_DATA_I,
	// Actuators
	output logic MOTOR_STEP_O,
	output logic MOTOR_CCW_O,
	output logic [3:0] DEV_CLUTCH_O,
	output logic [3:0] AGITATE_O,
	output logic SUPPLY_CLUTCH_O,
	output logic HOPPER_O,
	output logic AC_BIAS_O,
	output logic DC_BIAS_O,
	// Status
	output logic [3:0] NEAR_END_O,
	output logic [3:0] TONER_END_O,
	output logic COPY_STOP_O,
	output logic REST_FAULT_O,
	output logic OUT_OF_STEP_O,
	output logic SELF_CHECK_READY_O
);
	localparam int QSTEPS = STEPS_REV * rtec_pkg::QUARTER_DEG / 360;
	localparam int OSTEPS = STEPS_REV * rtec_pkg::OFFSET_DEG / 360;
	localparam int SMP_CYC = IV_CYC / rtec_pkg::SAMPLES;

	typedef enum logic [6:0] {
		S_LOOSEN = 7'h01,
		S_HOME = 7'h02,
		S_MOVE = 7'h04,
		S_DEV = 7'h08,
		S_IDLE = 7'h10,
		S_REC_SEL = 7'h20,
		S_REC_FEED = 7'h40
	} rtec_state_e;

	// Two-stage synchronisers
	logic [3:0] async_in;
	logic [3:0] meta_ff;
	logic [3:0] sync_ff;
	assign async_in = {DOOR_OPEN_I, LOCK_ENGAGED_I, TONER_END_SENSOR_I, REST_SENSOR_I};
	genvar gs;
	generate
		for (gs = 0; gs < 4; gs++)
		begin : g_sync
			always_ff @(posedge SYS_CLK_I)
			begin
				if (RST_I)
				begin
					meta_ff[gs] <= 1'b0;
					sync_ff[gs] <= 1'b0;
				end
				else
				begin
					meta_ff[gs] <= async_in[gs];
					sync_ff[gs] <= meta_ff[gs];
				end
			end
		end
	endgenerate
	logic rest_s, toner_s, lock_s, door_s;
	assign rest_s = sync_ff[0];
	assign toner_s = sync_ff[1];
	assign lock_s = sync_ff[2];
	assign door_s = sync_ff[3];
	logic rest_q_ff, door_q_ff;
	always_ff @(posedge SYS_CLK_I)
	begin
		rest_q_ff <= RST_I ? 1'b0 : rest_s;
		door_q_ff <= RST_I ? 1'b0 : door_s;
	end
	logic rest_enter, door_change;
	assign rest_enter = rest_s && !rest_q_ff; // RULE3
	assign door_change = door_s != door_q_ff;

	// AHB-Lite slave, zero wait states
	logic wr_ph_ff;
	logic [7:0] addr_ff;
	logic take;
	assign take = HSEL_I && HTRANS_I[1] && HREADY_I;
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			wr_ph_ff <= 1'b0;
			addr_ff <= 8'h00;
		end
		else
		begin
			wr_ph_ff <= take && HWRITE_I;
			if (take)
				addr_ff <= HADDR_I[7:0];
		end
	end
	logic [4:0] ctrl_p;
	logic pix_wr, sheet_wr;
	assign ctrl_p = (wr_ph_ff && addr_ff == rtec_pkg::OFS_CTRL) ? HWDATA_I[4:0] : 5'h00;
	assign pix_wr = wr_ph_ff && addr_ff == rtec_pkg::OFS_PIXEL;
	assign sheet_wr = wr_ph_ff && addr_ff == rtec_pkg::OFS_SHEET;
	logic [2:0] cfg_ff;
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
			cfg_ff <= rtec_pkg::CFG_RESET;
		else if (wr_ph_ff && addr_ff == rtec_pkg::OFS_CFG)
			cfg_ff <= HWDATA_I[2:0];
	end

	// Carrier state
	rtec_state_e state_ff, dst_ff;
	logic [8:0] pos_ff, target_ff;
	logic [10:0] steps_ff;
	logic [15:0] step_cnt_ff;
	logic [1:0] seq_ff, cur_col_ff;
	logic job_ff, self_ready_ff;
	logic [2:0] rec_col_ff;
	logic rec_pass_ff;
	logic [3:0] rec_fail_ff, rec_clr_ff;
	logic [3:0] near_ff, end_ff;
	logic [19:0] hop_cnt_ff;
	logic moving, step_go, home_hit, step_tick, park_need;
	assign moving = state_ff == S_LOOSEN || state_ff == S_HOME || state_ff == S_MOVE;
	assign step_go = moving && step_cnt_ff == 16'(STEP_CYC - 1);
	// No step on the cycle rest entry is seen, so the rest reference stays exact
	assign home_hit = state_ff == S_HOME && rest_enter; // RULE3
	assign step_tick = step_go && !home_hit;
	assign park_need = |near_ff || |end_ff;

	function automatic logic [8:0] station(input logic [1:0] col);
		station = 9'(OSTEPS + QSTEPS * int'(col)); // RULE2
	endfunction
	function automatic logic [1:0] order(input logic [1:0] idx, input logic prn);
		order = prn ? idx + rtec_pkg::COL_Y : idx; // RULE23
	endfunction

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I || !moving)
			step_cnt_ff <= 16'h0000;
		else
			step_cnt_ff <= step_go ? 16'h0000 : step_cnt_ff + 16'h0001;
	end

	// Motor drive: one pulse per step, direction fixed
	always_ff @(posedge SYS_CLK_I)
	begin
		MOTOR_STEP_O <= RST_I ? 1'b0 : step_tick;
		MOTOR_CCW_O <= 1'b1; // RULE1
	end

	// Fault flags
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			REST_FAULT_O <= 1'b0;
			OUT_OF_STEP_O <= 1'b0;
		end
		else
		begin
			if (moving && lock_s)
			begin
				OUT_OF_STEP_O <= 1'b1; // RULE22
				REST_FAULT_O <= 1'b1; // RULE22
			end
			else if (state_ff == S_HOME && step_tick && steps_ff >= 11'(rtec_pkg::HOME_LIMIT))
				REST_FAULT_O <= 1'b1; // RULE6
			else if (ctrl_p[rtec_pkg::CTRL_CLR_FAULT])
			begin
				REST_FAULT_O <= 1'b0;
				OUT_OF_STEP_O <= 1'b0;
			end
		end
	end

	// Sequencer
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			state_ff <= S_LOOSEN; // RULE21
			dst_ff <= S_IDLE;
			pos_ff <= 9'h000;
			target_ff <= 9'h000;
			steps_ff <= 11'h000;
			seq_ff <= 2'h0;
			cur_col_ff <= rtec_pkg::COL_K;
			job_ff <= 1'b0;
			self_ready_ff <= 1'b0;
			rec_col_ff <= 3'h0;
			rec_pass_ff <= 1'b0;
			rec_fail_ff <= 4'h0;
			rec_clr_ff <= 4'h0;
			hop_cnt_ff <= 20'h00000;
		end
		else
		begin
			rec_clr_ff <= 4'h0;
			if (step_tick)
			begin
				steps_ff <= steps_ff + 11'h001;
				pos_ff <= (pos_ff == 9'(STEPS_REV - 1)) ? 9'h000 : pos_ff + 9'h001;
			end
			if (moving && lock_s)
				state_ff <= S_IDLE;
			else if (door_change && state_ff != S_LOOSEN)
			begin
				state_ff <= S_HOME; // RULE4
				dst_ff <= S_IDLE;
				steps_ff <= 11'h000;
				job_ff <= 1'b0;
			end
			else
			begin
				case (state_ff)
					S_LOOSEN:
					begin
						if (step_tick && steps_ff == 11'(rtec_pkg::LOOSEN_TURNS * STEPS_REV - 1))
						begin
							state_ff <= S_HOME; // RULE4
							dst_ff <= S_IDLE;
							steps_ff <= 11'h000;
						end
					end
					S_HOME:
					begin
						if (rest_enter)
						begin
							pos_ff <= 9'h000; // RULE3
							self_ready_ff <= 1'b1; // RULE21
							steps_ff <= 11'h000;
							state_ff <= S_MOVE;
							if (dst_ff == S_DEV)
								target_ff <= station(cur_col_ff); // RULE2
							else if (park_need && !job_ff)
								target_ff <= 9'(rtec_pkg::PARK_STEP); // RULE5
							else
								state_ff <= dst_ff;
						end
						else if (steps_ff >= 11'(rtec_pkg::HOME_LIMIT))
							state_ff <= S_IDLE; // RULE6
					end
					S_MOVE:
					begin
						if (pos_ff == target_ff)
						begin
							state_ff <= dst_ff;
							self_ready_ff <= 1'b1;
						end
					end
					S_DEV:
					begin
						if (ctrl_p[rtec_pkg::CTRL_NEXT] && seq_ff != 2'h3)
						begin
							seq_ff <= seq_ff + 2'h1;
							cur_col_ff <= order(seq_ff + 2'h1, cfg_ff[rtec_pkg::CFG_PRINTER]);
							target_ff <= station(order(seq_ff + 2'h1, cfg_ff[rtec_pkg::CFG_PRINTER]));
							state_ff <= S_MOVE; // RULE1
						end
						else if (ctrl_p[rtec_pkg::CTRL_END])
						begin
							job_ff <= 1'b0;
							dst_ff <= S_IDLE;
							steps_ff <= 11'h000;
							state_ff <= S_HOME; // RULE4
						end
					end
					S_IDLE:
					begin
						if (ctrl_p[rtec_pkg::CTRL_START])
						begin
							job_ff <= 1'b1;
							seq_ff <= 2'h0;
							cur_col_ff <= order(2'h0, cfg_ff[rtec_pkg::CFG_PRINTER]);
							dst_ff <= S_DEV;
							steps_ff <= 11'h000;
							state_ff <= S_HOME; // RULE5
						end
						else if (ctrl_p[rtec_pkg::CTRL_RECOVER])
						begin
							rec_col_ff <= 3'h0;
							rec_pass_ff <= 1'b0;
							rec_fail_ff <= 4'h0;
							state_ff <= S_REC_SEL;
						end
					end
					S_REC_SEL:
					begin
						if (rec_col_ff[2])
						begin
							if (!rec_pass_ff && |rec_fail_ff)
							begin
								rec_pass_ff <= 1'b1; // RULE19
								rec_col_ff <= 3'h0;
							end
							else
							begin
								rec_clr_ff <= ~rec_fail_ff; // RULE20
								dst_ff <= S_IDLE;
								steps_ff <= 11'h000;
								state_ff <= S_HOME;
							end
						end
						else if (rec_pass_ff && !rec_fail_ff[rec_col_ff[1:0]])
							rec_col_ff <= rec_col_ff + 3'h1; // RULE19
						else
						begin
							cur_col_ff <= rec_col_ff[1:0]; // RULE18
							target_ff <= station(rec_col_ff[1:0]);
							dst_ff <= S_REC_FEED;
							hop_cnt_ff <= 20'h00000;
							state_ff <= S_MOVE;
						end
					end
					S_REC_FEED:
					begin
						hop_cnt_ff <= hop_cnt_ff + 20'h00001;
						if (hop_cnt_ff == 20'(HOP_CYC))
						begin
							rec_fail_ff[cur_col_ff] <= !toner_s; // RULE18
							rec_col_ff <= rec_col_ff + 3'h1;
							state_ff <= S_REC_SEL;
						end
					end
					default:
						state_ff <= S_IDLE;
				endcase
			end
		end
	end

	// Development, agitation, supply and bias drive
	logic dev, supplying;
	assign dev = state_ff == S_DEV;
	assign supplying = dev && cfg_ff[rtec_pkg::CFG_SUPPLY];
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			DEV_CLUTCH_O <= 4'h0;
			AGITATE_O <= 4'h0;
			SUPPLY_CLUTCH_O <= 1'b0;
			HOPPER_O <= 1'b0;
			AC_BIAS_O <= 1'b0;
			DC_BIAS_O <= 1'b0;
		end
		else
		begin
			DEV_CLUTCH_O <= (dev && job_ff) ? 4'h1 << cur_col_ff : 4'h0; // RULE7
			AGITATE_O <= ((dev && job_ff) || supplying
				|| (!moving && cfg_ff[rtec_pkg::CFG_PC_CHECK])) ? 4'h1 << cur_col_ff : 4'h0; // RULE8
			SUPPLY_CLUTCH_O <= supplying; // RULE11
			HOPPER_O <= state_ff == S_REC_FEED; // RULE18
			AC_BIAS_O <= dev && job_ff; // RULE9
			DC_BIAS_O <= 1'b1; // RULE9
		end
	end

	// Density readings from the unit at the station only
	logic [7:0] tds_ff;
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
			tds_ff <= 8'h00;
		else if (TDS_VALID_I && dev && TDS_UNIT_I == cur_col_ff)
			tds_ff <= TDS_DATA_I; // RULE10
	end

	// Toner end sensor sampling window
	logic [19:0] iv_cnt_ff;
	logic [15:0] smp_cnt_ff;
	logic [7:0] low_cnt_ff;
	logic iv_done_ff, absent_ff;
	logic smp_tick, iv_end;
	logic [7:0] low_sum;
	assign smp_tick = smp_cnt_ff == 16'(SMP_CYC - 1);
	assign iv_end = iv_cnt_ff == 20'(IV_CYC - 1);
	// Last sample of an interval is counted before the count restarts
	assign low_sum = low_cnt_ff + {7'h00, smp_tick && !toner_s}; // RULE12
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I || !dev)
		begin
			iv_cnt_ff <= 20'h00000;
			smp_cnt_ff <= 16'h0000;
			low_cnt_ff <= 8'h00;
			iv_done_ff <= 1'b0;
			absent_ff <= 1'b0;
		end
		else
		begin
			iv_cnt_ff <= iv_end ? 20'h00000 : iv_cnt_ff + 20'h00001; // RULE13
			smp_cnt_ff <= (smp_tick || iv_end) ? 16'h0000 : smp_cnt_ff + 16'h0001; // RULE13
			iv_done_ff <= iv_end;
			absent_ff <= low_sum >= 8'(rtec_pkg::LOW_THRESH); // RULE14
			low_cnt_ff <= iv_end ? 8'h00 : low_sum;
		end
	end

	// Per-colour near-end and end tracking
	logic [3:0] stop_c;
	genvar gc;
	generate
		for (gc = 0; gc < 4; gc++)
		begin : g_col
			logic [1:0] run_ff;
			logic [31:0] pix_ff;
			logic [3:0] sheet_ff;
			logic mine;
			assign mine = cur_col_ff == 2'(gc);
			always_ff @(posedge SYS_CLK_I)
			begin
				if (RST_I || rec_clr_ff[gc])
				begin
					run_ff <= 2'h0; // RULE20
					near_ff[gc] <= 1'b0;
					end_ff[gc] <= 1'b0;
					pix_ff <= 32'h00000000;
					sheet_ff <= 4'h0;
				end
				else
				begin
					if (iv_done_ff && mine)
					begin
						if (!absent_ff)
							run_ff <= 2'h0; // RULE24
						else if (run_ff == 2'(rtec_pkg::ABSENT_RUN - 1))
							near_ff[gc] <= 1'b1; // RULE15
						else
							run_ff <= run_ff + 2'h1; // RULE15
					end
					if (near_ff[gc] && pix_wr && mine && !end_ff[gc])
						pix_ff <= pix_ff + HWDATA_I;
					if (near_ff[gc] && pix_ff >= 32'(PIX_END))
						end_ff[gc] <= 1'b1; // RULE16
					if (near_ff[gc] && sheet_wr && mine && sheet_ff != 4'(rtec_pkg::END_SHEETS))
						sheet_ff <= sheet_ff + 4'h1;
				end
			end
			assign stop_c[gc] = end_ff[gc] && sheet_ff == 4'(rtec_pkg::END_SHEETS); // RULE17
		end
	endgenerate

	// Status outputs and read data
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			NEAR_END_O <= 4'h0;
			TONER_END_O <= 4'h0;
			COPY_STOP_O <= 1'b0;
			SELF_CHECK_READY_O <= 1'b0;
			HRDATA_O <= 32'h00000000;
			HREADYOUT_O <= 1'b1;
			HRESP_O <= 1'b0;
		end
		else
		begin
			NEAR_END_O <= near_ff;
			TONER_END_O <= end_ff;
			COPY_STOP_O <= |stop_c; // RULE17
			SELF_CHECK_READY_O <= self_ready_ff; // RULE21
			HREADYOUT_O <= 1'b1;
			HRESP_O <= 1'b0;
			HRDATA_O <= 32'h00000000;
			if (take && !HWRITE_I)
			begin
				case (HADDR_I[7:0])
					rtec_pkg::OFS_CFG: HRDATA_O <= {29'h0, cfg_ff};
					rtec_pkg::OFS_STATUS: HRDATA_O <= {5'h0, pos_ff, 3'h0, rec_col_ff,
						cur_col_ff, job_ff, OUT_OF_STEP_O, REST_FAULT_O, state_ff};
					rtec_pkg::OFS_TONER: HRDATA_O <= {19'h0, |stop_c, rec_fail_ff, end_ff, near_ff};
					rtec_pkg::OFS_TDS: HRDATA_O <= {24'h0, tds_ff};
					default: HRDATA_O <= 32'h00000000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// >>> verif/rtec_top_sva.sv
// Checker of port-level relations of the revolver and toner end controller
`timescale 1ns/10ps
`default_nettype none
module rtec_top_sva #(
	parameter int STEP_CYC = 4
) (
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	// Actuators
	input wire logic MOTOR_STEP_O,
	input wire logic MOTOR_CCW_O,
	input wire logic [3:0] DEV_CLUTCH_O,
	input wire logic [3:0] AGITATE_O,
	input wire logic SUPPLY_CLUTCH_O,
	input wire logic HOPPER_O,
	input wire logic AC_BIAS_O,
	input wire logic DC_BIAS_O,
	// Status
	input wire logic [3:0] NEAR_END_O,
	input wire logic [3:0] TONER_END_O,
	input wire logic COPY_STOP_O,
	input wire logic REST_FAULT_O,
	input wire logic OUT_OF_STEP_O,
	input wire logic SELF_CHECK_READY_O
);
	int gap_ff;
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RST_I);
	// Cycles since the last motor step, saturating at the step period
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			gap_ff <= STEP_CYC;
		end
		else if (MOTOR_STEP_O)
		begin
			gap_ff <= 1;
		end
		else if (gap_ff < STEP_CYC)
		begin
			gap_ff <= gap_ff + 1;
		end
	end
	a_ccw_only: assert property (MOTOR_STEP_O |-> MOTOR_CCW_O)
		else $error("motor stepped while not counterclockwise");
	a_step_gap: assert property (MOTOR_STEP_O |-> gap_ff >= STEP_CYC)
		else $error("motor steps closer than the step period");
	a_one_clutch: assert property ($onehot0(DEV_CLUTCH_O))
		else $error("several development clutches engaged");
	a_dev_agitate: assert property (DEV_CLUTCH_O != 4'h0 |-> AGITATE_O == DEV_CLUTCH_O)
		else $error("agitation differs from developing colour");
	a_dc_steady: assert property (!$past(RST_I) |-> DC_BIAS_O && !(AC_BIAS_O && !SELF_CHECK_READY_O))
		else $error("bias state wrong");
	a_supply_station: assert property (SUPPLY_CLUTCH_O |-> !MOTOR_STEP_O && $onehot(AGITATE_O))
		else $error("toner supply outside a station");
	a_end_near: assert property ((TONER_END_O & ~NEAR_END_O) == 4'h0)
		else $error("toner end without near end");
	a_stop_end: assert property (COPY_STOP_O |-> TONER_END_O != 4'h0)
		else $error("copy stop without toner end");
	a_hopper_still: assert property (HOPPER_O |-> !MOTOR_STEP_O)
		else $error("hopper fed while carrier moves");
	a_oos_fault: assert property ($rose(OUT_OF_STEP_O) |-> ##[0:2] REST_FAULT_O)
		else $error("out of step without rest fault code");
endmodule
bind rtec_top rtec_top_sva #(.STEP_CYC(STEP_CYC)) chk_u (
	.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .MOTOR_STEP_O(MOTOR_STEP_O),
	.MOTOR_CCW_O(MOTOR_CCW_O), .DEV_CLUTCH_O(DEV_CLUTCH_O), .AGITATE_O(AGITATE_O),
	.SUPPLY_CLUTCH_O(SUPPLY_CLUTCH_O), .HOPPER_O(HOPPER_O), .AC_BIAS_O(AC_BIAS_O),
	.DC_BIAS_O(DC_BIAS_O), .NEAR_END_O(NEAR_END_O), .TONER_END_O(TONER_END_O),
	.COPY_STOP_O(COPY_STOP_O), .REST_FAULT_O(REST_FAULT_O), .OUT_OF_STEP_O(OUT_OF_STEP_O),
	.SELF_CHECK_READY_O(SELF_CHECK_READY_O)
);
`default_nettype wire

// >>> verif/rtec_mech_model.sv
// Behavioural revolver mechanics: carrier position, rest and toner end sensors
`timescale 1ns/10ps
`default_nettype none
module rtec_mech_model #(
	parameter int STEPS_REV = 120,
	parameter int START_POS = 60
) (
	input wire logic clk_i,
	input wire logic step_i,
	input wire logic ccw_i,
	input wire logic lock_i,
	input wire logic [3:0] empty_i,
	output logic rest_o,
	output logic toner_o,
	output var int pos_o
);
	initial pos_o = START_POS;
	// A locked carrier does not move however the motor is pulsed
	always @(posedge clk_i)
	begin
		if (step_i && ccw_i && !lock_i)
		begin
			pos_o <= (pos_o + 1) % STEPS_REV;
		end
	end
	assign rest_o = pos_o < 3;
	// Mirror blocks line up only at a station; elsewhere the light path stays blocked
	always_comb
	begin
		toner_o = 1'b1;
		for (int c = 0; c < 4; c++)
		begin
			if (pos_o == STEPS_REV / 12 + c * STEPS_REV / 4 && empty_i[c])
			begin
				toner_o = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> verif/rtec_top_tb.sv
// Self-checking bench of the revolver controller against a mechanics model
`timescale 1ns/10ps
`default_nettype none
module rtec_top_tb;
	localparam int REV = 120;
	localparam int IV = 1600;
	logic clk, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, lock = 1'b0, door = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0, tds_unit = 2'h0;
	logic tds_valid = 1'b0, hready, hresp, rest, toner, step, ccw, supply, hopper, hop_prev;
	logic [7:0] tds_data = 8'h0;
	logic [3:0] clutch, agit, near, tend, empty = 4'h0;
	logic ac_bias, dc_bias, stop, rfault, oos, ready;
	int pos, miscompares, n_compared, hop_n;
	int hop_pos[8];
	rtec_top #(.STEPS_REV(REV), .STEP_CYC(4), .IV_CYC(IV), .HOP_CYC(8), .PIX_END(100)) dut_u (
		.SYS_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
		.HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
		.HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .REST_SENSOR_I(rest),
		.TONER_END_SENSOR_I(toner), .LOCK_ENGAGED_I(lock), .DOOR_OPEN_I(door),
		.TDS_VALID_I(tds_valid), .TDS_UNIT_I(tds_unit), .TDS_DATA_I(tds_data),
		.MOTOR_STEP_O(step), .MOTOR_CCW_O(ccw), .DEV_CLUTCH_O(clutch), .AGITATE_O(agit),
		.SUPPLY_CLUTCH_O(supply), .HOPPER_O(hopper), .AC_BIAS_O(ac_bias), .DC_BIAS_O(dc_bias),
		.NEAR_END_O(near), .TONER_END_O(tend), .COPY_STOP_O(stop), .REST_FAULT_O(rfault),
		.OUT_OF_STEP_O(oos), .SELF_CHECK_READY_O(ready)
	);
	rtec_mech_model #(.STEPS_REV(REV)) mech_u (.clk_i(clk), .step_i(step), .ccw_i(ccw),
		.lock_i(lock), .empty_i(empty), .rest_o(rest), .toner_o(toner), .pos_o(pos));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// The first eight hopper feeds are counted and the carrier position of each is kept
	always @(posedge clk)
	begin
		hop_prev <= hopper;
		if (hopper === 1'b1 && hop_prev === 1'b0 && hop_n < 8)
		begin
			hop_pos[hop_n] = pos;
			hop_n++;
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask
	task automatic wait_state(input logic [6:0] st);
		int n;
		n = 0;
		rd = 32'h0;
		while (rd[6:0] !== st && n < 4000)
		begin
			ahb(1'b0, 32'h08, 32'h0);
			n++;
		end
		chk("state", {25'h0, st}, {25'h0, rd[6:0]});
	endtask
	task automatic wait_clutch(input logic [3:0] e);
		int n;
		n = 0;
		while (clutch !== e && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic tds(input logic [1:0] u, input logic [7:0] d);
		@(posedge clk);
		tds_valid <= 1'b1;
		tds_unit <= u;
		tds_data <= d;
		@(posedge clk);
		tds_valid <= 1'b0;
	endtask
	task automatic t_power();
		int n, steps;
		n = 0;
		steps = 0;
		while (ready !== 1'b1 && n < 4000)
		begin
			@(posedge clk);
			n++;
			steps += (step === 1'b1);
		end
		chk("loosen", 32'h1, steps >= 3 * REV);
		chk("rest", 32'h1, rest);
		chk("biases", 32'h1, {ac_bias, dc_bias});
		chk("ccw", 32'h1, ccw);
		chk("okay", 32'h0, hresp);
		ahb(1'b0, 32'h04, 32'h0);
		chk("cfg reset", 32'h0, rd);
		ahb(1'b1, 32'h04, 32'h3);
		ahb(1'b0, 32'h04, 32'h0);
		chk("cfg", 32'h3, rd);
		chk("check agitate", 32'h1, agit);
		ahb(1'b0, 32'h40, 32'h0);
		chk("unmapped", 32'h0, rd);
		$display("power-on test done");
	endtask
	task automatic t_copy(input int first);
		ahb(1'b1, 32'h04, 32'(first));
		ahb(1'b1, 32'h00, 32'h1);
		wait_clutch(4'(1 << first));
		chk("first clutch", 32'(1 << first), clutch);
		chk("first station", 10 + 30 * first, pos);
		chk("ac bias", 32'h1, ac_bias);
		if (first == 0)
		begin
			tds(2'h0, 8'hA5);
			tds(2'h2, 8'h5A);
			ahb(1'b0, 32'h18, 32'h0);
			chk("density", 32'hA5, rd);
			ahb(1'b1, 32'h04, 32'h4);
			repeat (3) @(posedge clk);
			chk("supply", 32'h1, supply);
			chk("agitate", 32'h1, agit);
			ahb(1'b1, 32'h04, 32'h0);
		end
		ahb(1'b1, 32'h00, 32'h2);
		wait_clutch(4'(2 << first));
		chk("next station", 40 + 30 * first, pos);
		if (first == 0)
		begin
			ahb(1'b1, 32'h00, 32'h4);
		end
		else
		begin
			door <= ~door;
		end
		wait_state(7'h10);
		chk("homed", 32'h0, pos);
		chk("ac off", 32'h0, {ac_bias, clutch});
		$display("copy test done");
	endtask
	task automatic t_lock();
		int n;
		n = 0;
		lock <= 1'b1;
		ahb(1'b1, 32'h00, 32'h1);
		while (oos !== 1'b1 && n < 2000)
		begin
			@(posedge clk);
			n++;
		end
		repeat (3) @(posedge clk);
		chk("faults", 32'h3, {oos, rfault});
		lock <= 1'b0;
		ahb(1'b1, 32'h00, 32'h10);
		repeat (3) @(posedge clk);
		chk("faults cleared", 32'h0, {oos, rfault});
		wait_state(7'h10);
		$display("lock test done");
	endtask
	task automatic t_near();
		int n;
		n = 0;
		empty <= 4'h1;
		ahb(1'b1, 32'h04, 32'h0);
		ahb(1'b1, 32'h00, 32'h1);
		wait_clutch(4'h1);
		while (near[0] !== 1'b1 && n < 4 * IV)
		begin
			@(posedge clk);
			n++;
		end
		chk("near time", 32'h1, n >= 2 * IV && n < 4 * IV);
		ahb(1'b1, 32'h10, 32'd99);
		repeat (3) @(posedge clk);
		chk("end early", 32'h0, tend);
		ahb(1'b1, 32'h10, 32'd1);
		repeat (3) @(posedge clk);
		chk("end", 32'h1, tend);
		for (int i = 0; i < 10; i++)
		begin
			chk("stop early", 32'h0, stop);
			ahb(1'b1, 32'h14, 32'h1);
		end
		repeat (3) @(posedge clk);
		chk("stop", 32'h1, stop);
		ahb(1'b1, 32'h00, 32'h4);
		wait_state(7'h10);
		chk("park", rtec_pkg::PARK_STEP, pos);
		$display("near-end test done");
	endtask
	task automatic t_recover(input int feeds, input logic [3:0] left);
		hop_n = 0;
		ahb(1'b1, 32'h00, 32'h8);
		wait_state(7'h10);
		chk("feeds", feeds, hop_n);
		for (int i = 0; i < 4; i++)
		begin
			chk("feed station", 10 + 30 * i, hop_pos[i]);
		end
		chk("states", {24'h0, left, left}, {24'h0, near, tend});
		$display("recovery test done");
	endtask
	task automatic final_report();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
		begin
			$display("Simulation passed");
		end
		else
		begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial
	begin
		repeat (100000) @(posedge clk);
		miscompares++;
		final_report();
	end
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_power();
		t_copy(0);
		t_copy(1);
		t_lock();
		t_near();
		t_recover(5, 4'h1);
		empty <= 4'h0;
		t_recover(4, 4'h0);
		final_report();
	end
endmodule
`default_nettype wire
